// ---- usbhp_defs.svh ----
/*
  Register offsets, field positions, reset values and timing for the host pipe block.
  Assumes inclusion by bare name.
*/
`ifndef USBHP_DEFS_SVH
`define USBHP_DEFS_SVH
// ------
// Register byte offsets
// ------
`define USBHP_OFF_CTRL  8'h00
`define USBHP_OFF_HINT  8'h04
`define USBHP_OFF_PSEL  8'h08
`define USBHP_OFF_PCFG  8'h0C
`define USBHP_OFF_PSTAT 8'h10
`define USBHP_OFF_PIEN  8'h14
`define USBHP_OFF_PINRQ 8'h18
`define USBHP_OFF_PRST  8'h1C
`define USBHP_OFF_PDATA 8'h20
// ------
// Field positions
// ------
`define USBHP_CTRL_FRAME_MARKER_GEN_ENABLE   0
`define USBHP_CTRL_RSM    1
`define USBHP_HINT_WUP    0
`define USBHP_HINT_URSM   1
`define USBHP_HINT_RSENT  2
`define USBHP_CFG_EN      0
`define USBHP_CFG_TYP     1
`define USBHP_CFG_TOK     3
`define USBHP_CFG_DBL     5
`define USBHP_CFG_AUTO    6
`define USBHP_CFG_IMODE   7
`define USBHP_ST_TXO      0
`define USBHP_ST_RXI      1
`define USBHP_ST_CRC      2
`define USBHP_ST_FCON     3
`define USBHP_ST_FRZ      4
// ------
// Reset values and timing
// ------
`define USBHP_RST_CTRL    8'h00
`define USBHP_RST_INRQ    8'h00
`define USBHP_RESUME_MS   20
`define USBHP_CLK_KHZ     25000
`endif

// ---- usbhp_pkg.sv ----
/*
  Types shared by the host pipe block.
  Assumes nothing of its surroundings.
*/
package usbhp_pkg;
  typedef enum logic [1:0] {HS_READY, HS_SUSPEND, HS_RESUME} usbhp_hstate_t;
  typedef enum logic [1:0] {TK_SETUP, TK_IN, TK_OUT} usbhp_token_t;
  typedef enum logic [1:0] {PT_CTRL, PT_ISO, PT_BULK, PT_INTR} usbhp_ptype_t;
endpackage : usbhp_pkg

// ---- usbhp_bank_ram.sv ----
/*
  Pipe bank storage: NP pipes, two banks each, DEPTH bytes per bank.
  Assumes one write per port per cycle; reads are combinational.
*/
`timescale 1ns/100ps
`default_nettype none
module usbhp_bank_ram #(
  parameter int NP    = 2,
  parameter int DEPTH = 8,
  parameter int RW    = $clog2(NP) + 1 + $clog2(DEPTH)
) (
  // Clock
  input  wire logic          pclk,
  // CPU port
  input  wire logic          cpu_we,
  input  wire logic [RW-1:0] cpu_addr,
  input  wire logic [7:0]    cpu_wdata,
  output var  logic [7:0]    cpu_rdata,
  // Link port
  input  wire logic          lk_we,
  input  wire logic [RW-1:0] lk_addr,
  input  wire logic [7:0]    lk_wdata,
  output var  logic [7:0]    lk_rdata
);
  logic [7:0] mem [0:(1<<RW)-1];

  // The two ports can address one bank; if both write one address in a cycle, the link port write wins
  always_ff @(posedge pclk) begin
    if (cpu_we) begin
      mem[cpu_addr] <= cpu_wdata;
    end
    if (lk_we) begin
      mem[lk_addr] <= lk_wdata;
    end
  end

  always_comb begin
    cpu_rdata = mem[cpu_addr];
    lk_rdata  = mem[lk_addr];
  end
endmodule : usbhp_bank_ram
`default_nettype wire

// ---- usbhp_pipe_ctrl.sv ----
/*
  Host pipe controller: suspend and resume handling, pipe bank management,
  IN request counting and APB register access.
  Assumes an APB master and a USB engine that reports events as pulses.
*/
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "usbhp_defs.svh"
// Functional notes
// R1: Bus activity during suspend sets wakeup flag
// R2: K state also sets upstream resume flag
// R3: Firmware requests resume within 1ms, 20ms
// R4: Hardware sets frame marker enable after resume
// R5: Clearing frame marker enable enters suspend
// R6: Resume request self-clears; writing zero ignored
// R7: Suspend exits on enable or wakeup flag
// R8: Pipe reset clears banks, status; keeps config
// R9: Full pipe reset needs disable then enable
// R10: CPU reaches FIFO via select and data port
// R11: Firmware reprograms token per control phase
// R12: Control pipe toggle initialised per token
// R13: Ready OUT bank forces exit from suspend
// R14: OUT manual: free bank sets flag, control
// R15: CPU release moves bank, refreshes flags
// R16: OUT auto: full bank auto released
// R17: Count plus one IN requests, then freeze
// R18: Request mode one: unlimited IN requests
// R19: IN requests start when freeze cleared
// R20: IN manual: full bank sets flag, control
// R21: CPU release frees IN bank, switches bank
// R22: IN auto: empty bank auto released
// R23: Iso bad packet flags CRC, keeps receive
module usbhp_pipe_ctrl #(
  parameter int NP         = 2,
  parameter int DEPTH      = 8,
  parameter int RESUME_CYC = `USBHP_RESUME_MS * `USBHP_CLK_KHZ
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  // Bus state
  input  wire logic                  bus_nonidle,
  input  wire logic                  bus_kstate,
  output var  logic                  resume_drive,
  output var  logic                  frame_marker_active,
  // USB engine
  input  wire logic [$clog2(NP)-1:0] lk_pipe,
  input  wire logic                  lk_wr,
  input  wire logic [7:0]            lk_wdata,
  input  wire logic                  lk_in_end,
  input  wire logic                  lk_crc_err,
  input  wire logic                  lk_in_req,
  input  wire logic                  lk_rd,
  input  wire logic                  lk_out_end,
  output var  logic [7:0]            lk_rdata,
  output var  logic [NP-1:0]         in_req_en,
  output var  logic [NP-1:0]         out_ready,
  output var  logic [NP-1:0]         data_toggle,
  output var  logic                  pipe_irq
);
  localparam int PW = $clog2(NP);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(RESUME_CYC + 1);

  if (NP < 2 || NP > 8 || DEPTH < 2 || (1 << AW) != DEPTH || RESUME_CYC < 2) begin : g_chk
    $error("usbhp_pipe_ctrl: unsupported parameters");
  end

  typedef struct packed {
    usbhp_pkg::usbhp_hstate_t     st;
    logic                         frame_marker_gen_enable, rsm, wup, ursm, rsent;
    logic [CW-1:0]                rcnt;
    logic [PW-1:0]                sel;
    logic [NP-1:0]                en, dbl, auto, imode, frz, tog, txo, rxi, crc, fcon, cur, lkb, txe, rxe, cre;
    logic [NP-1:0][1:0]           typ, tok, full;
    logic [NP-1:0][7:0]           rql, rqc;
    logic [NP-1:0][AW-1:0]        cptr, lptr;
    logic [NP-1:0][1:0][AW:0]     cnt;
    logic                         rdy, err, irq, drv, sofo;
    logic [31:0]                  rdata;
    logic [7:0]                   lkd;
    logic [NP-1:0]                inrq, ordy;
  } usbhp_state_t;

  usbhp_state_t s_q, s_d;
  logic [7:0]   cpu_rd, lk_rd_b;
  logic         cpu_we, acc, done;

  function automatic logic is_out(input usbhp_state_t s, input int p);
    return s.tok[p] != 2'(usbhp_pkg::TK_IN);
  endfunction : is_out

  // Bank state and status back to initial values; configuration and toggle kept
  function automatic usbhp_state_t pinit(input usbhp_state_t s, input int p);
    s.full[p] = 2'h0;
    s.cur[p]  = 1'b0;
    s.lkb[p]  = 1'b0;
    s.cptr[p] = '0;
    s.lptr[p] = '0;
    s.rxi[p]  = 1'b0;
    s.crc[p]  = 1'b0;
    s.txo[p]  = is_out(s, p);
    s.fcon[p] = is_out(s, p);
    return s;
  endfunction : pinit

  // CPU hands the current bank back, then flags follow the next bank
  function automatic usbhp_state_t release_bank(input usbhp_state_t s, input int p);
    logic b;
    b = s.cur[p];
    s.full[p][b] = is_out(s, p);
    s.cnt[p][b]  = (AW+1)'(s.cptr[p]) + (AW+1)'(1);
    s.cptr[p]    = '0;
    b            = b ^ s.dbl[p];
    s.cur[p]     = b;
    if (is_out(s, p)) begin
      s.fcon[p] = ~s.full[p][b];
      s.txo[p]  = s.txo[p] | ~s.full[p][b];
    end else begin
      s.fcon[p] = s.full[p][b];
      s.rxi[p]  = s.rxi[p] | s.full[p][b];
    end
    return s;
  endfunction : release_bank

  assign acc  = psel & penable;
  assign done = acc & s_q.rdy;
  assign cpu_we = done & pwrite & (paddr == `USBHP_OFF_PDATA) & s_q.fcon[s_q.sel] & is_out(s_q, int'(s_q.sel));

  usbhp_bank_ram #(.NP(NP), .DEPTH(DEPTH)) u_ram (
    .pclk      (pclk),
    .cpu_we    (cpu_we),
    .cpu_addr  ({s_q.sel, s_q.cur[s_q.sel], s_q.cptr[s_q.sel]}),
    .cpu_wdata (pwdata[7:0]),
    .cpu_rdata (cpu_rd),
    .lk_we     (lk_wr),
    .lk_addr   ({lk_pipe, s_q.lkb[lk_pipe], s_q.lptr[lk_pipe]}),
    .lk_wdata  (lk_wdata),
    .lk_rdata  (lk_rd_b)
  );

  always_comb begin
    int  p;
    logic b;
    p   = int'(s_q.sel);
    b   = 1'b0;
    s_d = s_q;
    s_d.rdy = 1'b0;
    s_d.err = 1'b0;
    // ------
    // APB access phase
    // ------
    // One wait state: read data and error settle before pready
    if (acc && !s_q.rdy) begin
      s_d.rdy   = 1'b1;
      s_d.rdata = 32'h0;
      case (paddr)
        `USBHP_OFF_CTRL:  s_d.rdata = {28'h0, 2'(s_q.st), s_q.rsm, s_q.frame_marker_gen_enable};
        `USBHP_OFF_HINT:  s_d.rdata = {29'h0, s_q.rsent, s_q.ursm, s_q.wup};
        `USBHP_OFF_PSEL:  s_d.rdata = 32'(s_q.sel);
        `USBHP_OFF_PCFG:  s_d.rdata = {24'h0, s_q.imode[p], s_q.auto[p], s_q.dbl[p], s_q.tok[p], s_q.typ[p],
                                        s_q.en[p]};
        `USBHP_OFF_PSTAT: s_d.rdata = {25'h0, s_q.cur[p], s_q.tog[p], s_q.frz[p], s_q.fcon[p], s_q.crc[p],
                                        s_q.rxi[p], s_q.txo[p]};
        `USBHP_OFF_PIEN:  s_d.rdata = {29'h0, s_q.cre[p], s_q.rxe[p], s_q.txe[p]};
        `USBHP_OFF_PINRQ: s_d.rdata = {24'h0, s_q.rqc[p]};
        `USBHP_OFF_PRST:  s_d.rdata = 32'h0;
        `USBHP_OFF_PDATA: s_d.rdata = {24'h0, cpu_rd}; // R10
        default:          s_d.err   = 1'b1;
      endcase
    end
    if (done && pwrite) begin
      case (paddr)
        `USBHP_OFF_CTRL: begin
          s_d.frame_marker_gen_enable = pwdata[`USBHP_CTRL_FRAME_MARKER_GEN_ENABLE];
          s_d.rsm  = s_q.rsm | pwdata[`USBHP_CTRL_RSM]; // R6
        end
        `USBHP_OFF_HINT: begin
          s_d.wup   = s_q.wup & ~pwdata[`USBHP_HINT_WUP];
          s_d.ursm  = s_q.ursm & ~pwdata[`USBHP_HINT_URSM];
          s_d.rsent = s_q.rsent & ~pwdata[`USBHP_HINT_RSENT];
        end
        `USBHP_OFF_PSEL: s_d.sel = pwdata[PW-1:0]; // R10
        `USBHP_OFF_PCFG: begin
          s_d.en[p]    = pwdata[`USBHP_CFG_EN];
          s_d.typ[p]   = pwdata[`USBHP_CFG_TYP+:2];
          s_d.tok[p]   = pwdata[`USBHP_CFG_TOK+:2];
          s_d.dbl[p]   = pwdata[`USBHP_CFG_DBL] & (pwdata[`USBHP_CFG_TYP+:2] != 2'(usbhp_pkg::PT_CTRL));
          s_d.auto[p]  = pwdata[`USBHP_CFG_AUTO];
          s_d.imode[p] = pwdata[`USBHP_CFG_IMODE];
          if (!s_q.en[p]) begin
            s_d.frz[p] = 1'b1;
            s_d.tog[p] = 1'b0;
          end
          if (pwdata[`USBHP_CFG_TYP+:2] == 2'(usbhp_pkg::PT_CTRL)) begin
            s_d.tog[p] = pwdata[`USBHP_CFG_TOK+:2] != 2'(usbhp_pkg::TK_SETUP); // R12
          end
          s_d = pinit(s_d, p);
          if (!pwdata[`USBHP_CFG_EN]) begin
            s_d.txo[p]  = 1'b0;
            s_d.fcon[p] = 1'b0;
          end
        end
        `USBHP_OFF_PSTAT: begin
          s_d.txo[p] = s_q.txo[p] & ~pwdata[`USBHP_ST_TXO];
          s_d.rxi[p] = s_q.rxi[p] & ~pwdata[`USBHP_ST_RXI];
          s_d.crc[p] = s_q.crc[p] & ~pwdata[`USBHP_ST_CRC];
          s_d.frz[p] = pwdata[`USBHP_ST_FRZ];
          if (s_q.frz[p] && !pwdata[`USBHP_ST_FRZ]) begin
            s_d.rql[p] = s_q.rqc[p]; // R19
          end
          if (s_q.fcon[p] && !pwdata[`USBHP_ST_FCON]) begin
            s_d = release_bank(s_d, p); // R15 R21
          end
        end
        `USBHP_OFF_PIEN: begin
          s_d.txe[p] = pwdata[0];
          s_d.rxe[p] = pwdata[1];
          s_d.cre[p] = pwdata[2];
        end
        `USBHP_OFF_PINRQ: s_d.rqc[p] = pwdata[7:0];
        `USBHP_OFF_PRST: begin
          for (int i = 0; i < NP; i++) begin
            if (pwdata[i] && s_q.en[i]) begin
              s_d = pinit(s_d, i); // R8
            end
          end
        end
        `USBHP_OFF_PDATA: begin
          if (cpu_we) begin
            s_d.cptr[p] = s_q.cptr[p] + AW'(1);
            if (s_q.auto[p] && s_q.cptr[p] == AW'(DEPTH - 1)) begin
              s_d = release_bank(s_d, p); // R16
            end
          end
        end
        default: ;
      endcase
    end
    // Data port read advances the pointer of an IN bank owned by the CPU
    if (done && !pwrite && paddr == `USBHP_OFF_PDATA && s_q.fcon[p] && !is_out(s_q, p)) begin
      s_d.cptr[p] = s_q.cptr[p] + AW'(1);
      if (s_q.auto[p] && (AW+1)'(s_q.cptr[p]) + (AW+1)'(1) >= s_q.cnt[p][s_q.cur[p]]) begin
        s_d = release_bank(s_d, p); // R22
      end
    end
    // ------
    // USB engine events, applied after CPU clears so sets win
    // ------
    p = int'(lk_pipe);
    b = s_q.lkb[p];
    if (lk_wr || lk_rd) begin
      s_d.lptr[p] = s_q.lptr[p] + AW'(1);
    end
    if (lk_rd) begin
      s_d.lkd = lk_rd_b;
    end
    if (lk_in_req && !s_q.imode[p]) begin
      if (s_q.rql[p] == 8'h00) begin
        s_d.frz[p] = 1'b1; // R17
      end else begin
        s_d.rql[p] = s_q.rql[p] - 8'h01; // R17
      end
    end
    if (lk_in_end) begin
      s_d.cnt[p][b]  = (AW+1)'(s_q.lptr[p]) + (AW+1)'(lk_wr);
      s_d.lptr[p]    = '0;
      s_d.full[p][b] = 1'b1;
      s_d.lkb[p]     = b ^ s_q.dbl[p];
      if (lk_crc_err && s_q.typ[p] == 2'(usbhp_pkg::PT_ISO)) begin
        s_d.crc[p] = 1'b1; // R23
      end else begin
        s_d.tog[p] = ~s_q.tog[p];
      end
      if (b == s_d.cur[p] && !s_d.fcon[p]) begin
        s_d.fcon[p] = 1'b1; // R20 R22
        s_d.rxi[p]  = 1'b1; // R20 R23
      end
    end
    if (lk_out_end) begin
      s_d.full[p][b] = 1'b0;
      s_d.lptr[p]    = '0;
      s_d.tog[p]     = ~s_q.tog[p];
      s_d.lkb[p]     = b ^ s_q.dbl[p];
      if (b == s_d.cur[p] && !s_d.fcon[p]) begin
        s_d.fcon[p] = 1'b1; // R14 R16
        s_d.txo[p]  = 1'b1; // R14 R16
      end
    end
    // ------
    // Suspend and resume sequencing
    // ------
    case (s_q.st)
      usbhp_pkg::HS_READY: begin
        if (s_q.rsm) begin
          s_d.st   = usbhp_pkg::HS_RESUME;
          s_d.rcnt = '0;
        end else if (!s_q.frame_marker_gen_enable && !s_q.wup && !(|s_q.ordy)) begin
          s_d.st = usbhp_pkg::HS_SUSPEND; // R5 R13
        end
      end
      usbhp_pkg::HS_SUSPEND: begin
        if (bus_nonidle) begin
          s_d.wup = 1'b1; // R1
        end
        if (bus_nonidle && bus_kstate) begin
          s_d.ursm = 1'b1; // R2
        end
        if (s_q.rsm) begin
          s_d.st   = usbhp_pkg::HS_RESUME;
          s_d.rcnt = '0;
        end else if (s_q.frame_marker_gen_enable || s_q.wup || (|s_q.ordy)) begin
          s_d.st = usbhp_pkg::HS_READY; // R7 R13
        end
      end
      usbhp_pkg::HS_RESUME: begin
        s_d.rcnt = s_q.rcnt + CW'(1);
        // Resume length is fixed here, so firmware only has to set the request in time
        if (s_q.rcnt == CW'(RESUME_CYC - 1)) begin
          s_d.st    = usbhp_pkg::HS_READY;
          s_d.rsm   = 1'b0; // R6
          s_d.frame_marker_gen_enable  = 1'b1; // R4
          s_d.rsent = 1'b1;
        end
      end
      default: s_d.st = usbhp_pkg::HS_READY;
    endcase
    // ------
    // Registered outputs from next state
    // ------
    for (int i = 0; i < NP; i++) begin
      s_d.inrq[i] = s_d.en[i] && !is_out(s_d, i) && !s_d.frz[i] && !s_d.full[i][s_d.lkb[i]] &&
                    s_d.st == usbhp_pkg::HS_READY; // R18 R19
      s_d.ordy[i] = s_d.en[i] && is_out(s_d, i) && s_d.full[i][s_d.lkb[i]];
    end
    s_d.irq  = |((s_d.txo & s_d.txe) | (s_d.rxi & s_d.rxe) | (s_d.crc & s_d.cre)); // R14 R20
    s_d.drv  = s_d.st == usbhp_pkg::HS_RESUME;
    s_d.sofo = s_d.st == usbhp_pkg::HS_READY && s_d.frame_marker_gen_enable; // R5
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q      <= '0;
      s_q.st   <= usbhp_pkg::HS_READY;
      s_q.frame_marker_gen_enable <= 1'(`USBHP_RST_CTRL >> `USBHP_CTRL_FRAME_MARKER_GEN_ENABLE);
      s_q.frz  <= '1;
      s_q.rqc  <= {NP{`USBHP_RST_INRQ}};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata              = s_q.rdata;
  assign pready              = s_q.rdy;
  assign pslverr             = s_q.err;
  assign resume_drive        = s_q.drv;
  assign frame_marker_active = s_q.sofo;
  assign lk_rdata            = s_q.lkd;
  assign in_req_en           = s_q.inrq;
  assign out_ready           = s_q.ordy;
  assign data_toggle         = s_q.tog;
  assign pipe_irq            = s_q.irq;
endmodule : usbhp_pipe_ctrl
`default_nettype wire

// ---- usbhp_pipe_ctrl_props.sv ----
/* Port checker for the host pipe controller.
   Bound into usbhp_pipe_ctrl; sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module usbhp_pipe_ctrl_props #(
  parameter int NP         = 2,
  parameter int RESUME_CYC = 8
) (
  // Clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  // APB
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic          pready,
  input wire logic          pslverr,
  // Bus and engine
  input wire logic          resume_drive,
  input wire logic          frame_marker_active,
  input wire logic          lk_in_req,
  input wire logic          lk_in_end,
  input wire logic          lk_out_end,
  input wire logic [NP-1:0] in_req_en,
  input wire logic [NP-1:0] data_toggle,
  input wire logic          pipe_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic apb_wr;
  logic req_ev;
  logic any_ev;
  int   rcnt_q;
  assign apb_wr = psel & penable & pready & pwrite;
  assign req_ev = apb_wr | lk_in_req;
  assign any_ev = apb_wr | lk_in_end | lk_out_end;
  // Resume length; too long for a repetition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rcnt_q <= 0;
    else rcnt_q <= resume_drive ? rcnt_q + 1 : 0;
  end
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_rsm_end;
    resume_drive ##1 !resume_drive;
  endsequence
  AST_APB_WAIT: assert property (s_wait |=> pready)
    else $error("no answer after wait state");
  AST_APB_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_APB_ERR: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside access");
  AST_RSM_LEN: assert property ($fell(resume_drive) |-> rcnt_q >= RESUME_CYC)
    else $error("resume too short");
  AST_SOF_AFTER: assert property (s_rsm_end |-> ##[0:2] frame_marker_active)
    else $error("frames not started after resume");
  AST_RSM_EXCL: assert property (resume_drive |-> !frame_marker_active)
    else $error("frames during resume");
  AST_REQ_START: assert property ((in_req_en & ~$past(in_req_en)) != '0 |-> $past(apb_wr))
    else $error("requests began without firmware");
  AST_REQ_STOP: assert property ((~in_req_en & $past(in_req_en)) != '0 |-> $past(req_ev))
    else $error("requests stopped without cause");
  AST_TOG: assert property (data_toggle != $past(data_toggle) |-> $past(any_ev))
    else $error("toggle changed without cause");
  AST_IRQ: assert property ($rose(pipe_irq) |-> $past(any_ev))
    else $error("irq rose without cause");
endmodule : usbhp_pipe_ctrl_props
bind usbhp_pipe_ctrl usbhp_pipe_ctrl_props #(.NP(NP), .RESUME_CYC(RESUME_CYC)) usbhp_pipe_ctrl_props_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .resume_drive,
  .frame_marker_active, .lk_in_req, .lk_in_end, .lk_out_end, .in_req_en, .data_toggle, .pipe_irq
);
`default_nettype wire

// ---- usbhp_dev_model.sv ----
/* Device and link engine model facing the host pipe block.
   Pipe 0 carries IN traffic, pipe 1 OUT; the bench keeps them apart. */
`timescale 1ns/100ps
`default_nettype none
module usbhp_dev_model #(
  parameter int DP = 8
) (
  // Clock, reset, bench commands
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            k_go,
  input  wire logic            in_go,
  input  wire logic            in_crc,
  input  wire logic [7:0]      in_seed,
  // Host levels
  input  wire logic [1:0]      in_req_en,
  input  wire logic [1:0]      out_ready,
  input  wire logic [7:0]      lk_rdata,
  // Bus and engine events
  output var  logic            bus_nonidle,
  output var  logic            bus_kstate,
  output var  logic            lk_pipe,
  output var  logic            lk_wr,
  output var  logic [7:0]      lk_wdata,
  output var  logic            lk_in_end,
  output var  logic            lk_crc_err,
  output var  logic            lk_in_req,
  output var  logic            lk_rd,
  output var  logic            lk_out_end,
  output var  logic [DP*8-1:0] out_bytes
);
  int   kc, ic, oc, ci, rc;
  logic r1;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {bus_nonidle, bus_kstate, lk_pipe, lk_wr, lk_in_end, r1} <= '0;
      {lk_crc_err, lk_in_req, lk_rd, lk_out_end, lk_wdata, out_bytes} <= '0;
      {kc, oc, ci, rc} <= '0;
      ic <= DP + 1;
    end else begin
      {lk_wr, lk_in_end, lk_crc_err, lk_in_req, lk_rd, lk_out_end} <= '0;
      r1 <= lk_rd;
      kc <= k_go ? 6 : (kc > 0 ? kc - 1 : 0);
      bus_nonidle <= kc > 0;
      bus_kstate <= kc > 0;
      if (in_go) ic <= 0;
      else if (ic < DP) begin
        lk_pipe <= 1'b0;
        lk_wr <= 1'b1;
        lk_wdata <= in_seed + ic[7:0];
        ic <= ic + 1;
      end else if (ic == DP) begin
        lk_in_end <= 1'b1;
        lk_crc_err <= in_crc;
        // Released data line must not look valid
        lk_wdata <= ~lk_wdata;
        ic <= ic + 1;
      end else if (in_req_en[0]) begin
        rc <= rc + 1;
        lk_pipe <= 1'b0;
        // Spacing of 3 keeps a request from racing the freeze
        lk_in_req <= rc % 3 == 0;
      end else if (out_ready[1] && oc < DP + 3) begin
        lk_pipe <= 1'b1;
        lk_rd <= oc < DP;
        lk_out_end <= oc == DP + 2;
        oc <= oc + 1;
      end
      if (!out_ready[1]) oc <= 0;
      if (oc == 0) ci <= 0;
      if (r1) begin
        out_bytes[ci*8 +: 8] <= lk_rdata;
        ci <= ci + 1;
      end
    end
  end
endmodule : usbhp_dev_model
`default_nettype wire

// ---- usbhp_pipe_ctrl_tb.sv ----
/* Self-checking bench for the host pipe controller.
   Needs the design, the device model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`include "usbhp_defs.svh"
module usbhp_pipe_ctrl_tb;
  localparam int DP = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, lk_wdata, lk_rdata, in_seed;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        resume_drive, frame_marker_active, pipe_irq, bus_nonidle, bus_kstate;
  logic        lk_pipe, lk_wr, lk_in_end, lk_crc_err, lk_in_req, lk_rd, lk_out_end;
  logic [1:0]  in_req_en, out_ready, data_toggle;
  logic        k_go, in_go, in_crc;
  logic [63:0] out_bytes, exp_out;
  int          n_mismatch, n_checks, n_req, cyc, n;

  usbhp_pipe_ctrl #(.NP(2), .DEPTH(DP), .RESUME_CYC(8)) usbhp_pipe_ctrl_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .bus_nonidle, .bus_kstate, .resume_drive, .frame_marker_active,
    .lk_pipe, .lk_wr, .lk_wdata, .lk_in_end, .lk_crc_err, .lk_in_req, .lk_rd,
    .lk_out_end, .lk_rdata, .in_req_en, .out_ready, .data_toggle, .pipe_irq);
  usbhp_dev_model #(.DP(DP)) usbhp_dev_model_i (
    .pclk, .presetn, .k_go, .in_go, .in_crc, .in_seed, .in_req_en, .out_ready,
    .lk_rdata, .bus_nonidle, .bus_kstate, .lk_pipe, .lk_wr, .lk_wdata, .lk_in_end,
    .lk_crc_err, .lk_in_req, .lk_rd, .lk_out_end, .out_bytes);

  // ------
  // Helpers
  // ------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] in_byte(input logic [7:0] s, input int i);
    return s + i[7:0];
  endfunction : in_byte
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] ex);
    n_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk(nm, rd & m, ex);
  endtask : rdchk
  task automatic idle(input int c);
    repeat (c) @(posedge pclk);
  endtask : idle
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  // Hang guard, also counts issued IN requests
  always @(posedge pclk) begin
    cyc++;
    if (lk_in_req === 1'b1) n_req++;
    if (cyc == 30000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ------
  // Sequence
  // ------
  initial begin
    {psel, penable, pwrite, k_go, in_go, in_crc, presetn, paddr, pwdata, in_seed} = '0;
    seed = 32'h5956567D;
    idle(20);
    presetn <= 1'b1;
    rdchk("ctrl", `USBHP_OFF_CTRL, 32'h3, {24'h0, `USBHP_RST_CTRL});
    rdchk("hint", `USBHP_OFF_HINT, 32'h7, 32'h0);
    rdchk("inrq", `USBHP_OFF_PINRQ, 32'hFF, {24'h0, `USBHP_RST_INRQ});
    apb(1'b0, 8'h24, 32'h0);
    chk("slverr", er, 1'b1);
    k_go <= 1'b1;
    idle(1);
    k_go <= 1'b0;
    idle(10);
    rdchk("wake", `USBHP_OFF_HINT, 32'h3, 32'h3);
    apb(1'b1, `USBHP_OFF_CTRL, 32'h2);
    while (resume_drive !== 1'b1) @(posedge pclk);
    while (resume_drive === 1'b1) @(posedge pclk);
    idle(2);
    chk("sof", frame_marker_active, 1'b1);
    rdchk("ctrl", `USBHP_OFF_CTRL, 32'hF, 32'h1);
    apb(1'b1, `USBHP_OFF_HINT, 32'h7);
    apb(1'b1, `USBHP_OFF_CTRL, 32'h0);
    idle(2);
    rdchk("susp", `USBHP_OFF_CTRL, 32'hF, 32'h4);
    chk("nosof", frame_marker_active, 1'b0);
    apb(1'b1, `USBHP_OFF_CTRL, 32'h1);
    idle(2);
    rdchk("ready", `USBHP_OFF_CTRL, 32'hF, 32'h1);
    apb(1'b1, `USBHP_OFF_PSEL, 32'h1);
    for (int t = 0; t < 3; t++) begin
      apb(1'b1, `USBHP_OFF_PCFG, 32'h0);
      apb(1'b1, `USBHP_OFF_PCFG, {27'h0, t[1:0], 3'h1});
      idle(2);
      chk("toggle", data_toggle[1], t != 0);
    end
    apb(1'b1, `USBHP_OFF_PRST, 32'h2);
    idle(2);
    rdchk("cfg", `USBHP_OFF_PCFG, 32'hFF, 32'h11);
    chk("keep", data_toggle[1], 1'b1);
    apb(1'b1, `USBHP_OFF_PSTAT, 32'h8);
    rdchk("txfree", `USBHP_OFF_PSTAT, 32'h9, 32'h9);
    for (int i = 0; i < DP; i++) begin
      seed = lfsr(seed);
      exp_out[i*8 +: 8] = seed[7:0];
      apb(1'b1, `USBHP_OFF_PDATA, {24'h0, seed[7:0]});
    end
    apb(1'b1, `USBHP_OFF_PSTAT, 32'h1);
    while (out_ready[1] !== 1'b1) @(posedge pclk);
    while (out_ready[1] === 1'b1) @(posedge pclk);
    chk("out", out_bytes, exp_out);
    idle(2);
    rdchk("txnext", `USBHP_OFF_PSTAT, 32'h9, 32'h9);
    apb(1'b1, `USBHP_OFF_PIEN, 32'h1);
    idle(3);
    chk("txirq", pipe_irq, 1'b1);
    apb(1'b1, `USBHP_OFF_PIEN, 32'h0);
    idle(3);
    chk("txmask", pipe_irq, 1'b0);
    apb(1'b1, `USBHP_OFF_PSEL, 32'h0);
    apb(1'b1, `USBHP_OFF_PCFG, 32'h0D);
    seed = lfsr(seed);
    n = int'(seed[1:0]);
    apb(1'b1, `USBHP_OFF_PINRQ, {30'h0, seed[1:0]});
    idle(2);
    chk("frozen", in_req_en[0], 1'b0);
    n_req = 0;
    apb(1'b1, `USBHP_OFF_PSTAT, 32'h8);
    while (in_req_en[0] !== 1'b1) @(posedge pclk);
    while (in_req_en[0] === 1'b1) @(posedge pclk);
    idle(3);
    chk("nreq", n_req, n + 1);
    apb(1'b1, `USBHP_OFF_PCFG, 32'h8D);
    apb(1'b1, `USBHP_OFF_PSTAT, 32'h8);
    idle(40);
    chk("endless", in_req_en[0], 1'b1);
    apb(1'b1, `USBHP_OFF_PSTAT, 32'h18);
    idle(3);
    chk("stopped", in_req_en[0], 1'b0);
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, `USBHP_OFF_PCFG, c ? 32'h0B : 32'h0D);
      apb(1'b1, `USBHP_OFF_PIEN, 32'h2);
      seed = lfsr(seed);
      in_seed <= seed[7:0];
      in_crc <= c[0];
      in_go <= 1'b1;
      idle(1);
      in_go <= 1'b0;
      while (pipe_irq !== 1'b1) @(posedge pclk);
      rdchk("rxflags", `USBHP_OFF_PSTAT, 32'hE, c ? 32'hE : 32'hA);
      for (int i = 0; i < DP; i++) rdchk("byte", `USBHP_OFF_PDATA, 32'hFF, {24'h0, in_byte(seed[7:0], i)});
      apb(1'b1, `USBHP_OFF_PSTAT, 32'h6);
      idle(3);
      chk("ack", pipe_irq, 1'b0);
      rdchk("rxfree", `USBHP_OFF_PSTAT, 32'hA, 32'h0);
    end
    summarize();
  end
endmodule : usbhp_pipe_ctrl_tb
`default_nettype wire
